// >>> hw/spr_readout.v
`timescale 1ns/100ps
`default_nettype none
`include "spr_readout_regs.vh"

// Pixel readout port: scans the array on master clock rising edges and drives the pixel bus.
module spr_readout #(
	parameter BLACK_LEVEL = 10'h0_020
) (
	input wire sys_clk,
	input wire resetn,
	input wire master_clock_in,
	input wire output_disable,
	input wire snapshot_req,
	input wire standby_req,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	output reg [9:0] pixel_data,
	output reg frame_active,
	output reg line_active,
	output reg pixel_out_clock,
	output reg reset_done,
	output reg out_en_n,
	output reg analog_bias_on
);

	// Scan states.
	localparam ST_IDLE = 1'b0;
	localparam ST_SCAN = 1'b1;

	// Decodes whether an array location lies in the black border.
	function is_black;
		input [10:0] row_a;
		input [10:0] col_a;
		begin
			is_black = (row_a < `SPR_BLACK_TOP) ||
				(row_a >= (`SPR_ARRAY_ROWS - `SPR_BLACK_BOTTOM)) ||
				(col_a < `SPR_BLACK_LEFT) ||
				(col_a >= (`SPR_ARRAY_COLS - `SPR_BLACK_RIGHT));
		end
	endfunction

	// Synchroniser stages for the asynchronous inputs.
	reg mclk_s1_reg;
	reg mclk_s2_reg;
	reg oe_s1_reg;
	reg oe_s2_reg;
	reg snap_s1_reg;
	reg snap_s2_reg;
	reg stby_s1_reg;
	reg stby_s2_reg;

	// Software registers.
	reg [15:0] row_size_reg;
	reg [15:0] column_size_reg;
	reg [15:0] horiz_blank_reg;
	reg [15:0] vert_blank_reg;
	reg [15:0] integration_rows_reg;
	reg [15:0] readout_mode_reg;

	// Scan state and counters.
	reg state_reg;
	reg state_next;
	reg [17:0] col_reg;
	reg [17:0] col_next;
	reg [16:0] row_reg;
	reg [16:0] row_next;

	// Derived row and frame timing.
	reg [15:0] hblank_eff;
	reg [15:0] p2_len;
	reg [15:0] col_size_eff;
	reg [17:0] act_len;
	reg [17:0] row_len;
	reg [16:0] out_rows;
	reg [16:0] norm_rows;
	reg [16:0] integ_rows;
	reg [16:0] frame_rows;

	// Output values computed for the next pixel step.
	reg fa_next;
	reg lv_next;
	reg strobe_next;
	reg [9:0] data_next;
	reg in_cols;
	reg in_rows;
	reg [10:0] row_addr;
	reg [10:0] col_addr;
	reg [17:0] pix_idx;

	// One master clock rising edge seen in the system clock domain.
	wire pix_step;
	wire raw_mode;
	wire snap_mode;
	wire [1:0] skip_mode;

	assign pix_step = mclk_s2_reg & ~pixel_out_clock;
	assign raw_mode = readout_mode_reg[`SPR_MODE_RAW_BIT];
	assign snap_mode = readout_mode_reg[`SPR_MODE_SNAP_BIT];
	assign skip_mode = readout_mode_reg[`SPR_MODE_SKIP_LSB+1:`SPR_MODE_SKIP_LSB];

	// Two flip-flops on every input from outside this clock domain.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mclk_s1_reg <= 1'b0;
			mclk_s2_reg <= 1'b0;
			oe_s1_reg <= 1'b1;
			oe_s2_reg <= 1'b1;
			snap_s1_reg <= 1'b0;
			snap_s2_reg <= 1'b0;
			stby_s1_reg <= 1'b0;
			stby_s2_reg <= 1'b0;
		end else begin
			mclk_s1_reg <= master_clock_in;
			mclk_s2_reg <= mclk_s1_reg;
			oe_s1_reg <= output_disable;
			oe_s2_reg <= oe_s1_reg;
			snap_s1_reg <= snapshot_req;
			snap_s2_reg <= snap_s1_reg;
			stby_s1_reg <= standby_req;
			stby_s2_reg <= stby_s1_reg;
		end
	end

	// Register writes; the asynchronous reset restores every default.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			row_size_reg <= `SPR_ROW_SIZE_RST;
			column_size_reg <= `SPR_COL_SIZE_RST;
			horiz_blank_reg <= `SPR_HBLANK_RST;
			vert_blank_reg <= `SPR_VBLANK_RST;
			integration_rows_reg <= `SPR_INTEG_RST;
			readout_mode_reg <= `SPR_MODE_RST;
		end else if (reg_wr) begin
			// Unmapped and read-only addresses ignore writes.
			case (reg_addr)
				`SPR_ROW_SIZE_ADDR: begin
					row_size_reg <= reg_wdata;
				end
				`SPR_COL_SIZE_ADDR: begin
					column_size_reg <= reg_wdata;
				end
				`SPR_HBLANK_ADDR: begin
					horiz_blank_reg <= reg_wdata;
				end
				`SPR_VBLANK_ADDR: begin
					vert_blank_reg <= reg_wdata;
				end
				`SPR_INTEG_ADDR: begin
					integration_rows_reg <= reg_wdata;
				end
				`SPR_MODE_ADDR: begin
					readout_mode_reg <= reg_wdata;
				end
				default: begin
					row_size_reg <= row_size_reg;
				end
			endcase
		end
	end

	// Read data stand in the cycle after the read strobe; unmapped reads give zero.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`SPR_ROW_SIZE_ADDR: begin
					reg_rdata <= row_size_reg;
				end
				`SPR_COL_SIZE_ADDR: begin
					reg_rdata <= column_size_reg;
				end
				`SPR_HBLANK_ADDR: begin
					reg_rdata <= horiz_blank_reg;
				end
				`SPR_VBLANK_ADDR: begin
					reg_rdata <= vert_blank_reg;
				end
				`SPR_INTEG_ADDR: begin
					reg_rdata <= integration_rows_reg;
				end
				`SPR_MODE_ADDR: begin
					reg_rdata <= readout_mode_reg;
				end
				`SPR_STATUS_ADDR: begin
					// Live scan state: frame, line, standby, scanning, low row bits.
					reg_rdata <= {frame_active, line_active, stby_s2_reg, state_reg,
						row_reg[11:0]};
				end
				default: begin
					reg_rdata <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Row and frame lengths derived from the programmed sizes.
	always @* begin
		// Values under the minimum horizontal blanking are treated as the minimum.
		if (horiz_blank_reg < `SPR_HBLANK_MIN) begin
			hblank_eff = `SPR_HBLANK_MIN;
		end else begin
			hblank_eff = horiz_blank_reg;
		end
		p2_len = hblank_eff - `SPR_P2_BASE;
		// Column skip shrinks the column size that the row timing uses.
		case (skip_mode)
			2'd1: begin
				col_size_eff = {1'b0, column_size_reg[15:2], 1'b1};
			end
			2'd2: begin
				col_size_eff = {2'b00, column_size_reg[15:3], 1'b1};
			end
			2'd3: begin
				col_size_eff = {3'b000, column_size_reg[15:4], 1'b1};
			end
			default: begin
				col_size_eff = column_size_reg;
			end
		endcase
		act_len = {2'b00, col_size_eff} + 18'h0_0001;
		row_len = `SPR_P1_LEN + act_len + {2'b00, p2_len};
		// Raw mode adds the top and bottom black rows to the output.
		if (raw_mode) begin
			out_rows = {1'b0, row_size_reg} + 17'h0_0001 +
				{6'h00, `SPR_BLACK_TOP + `SPR_BLACK_BOTTOM};
		end else begin
			out_rows = {1'b0, row_size_reg} + 17'h0_0001;
		end
		norm_rows = out_rows + {1'b0, vert_blank_reg} + 17'h0_0001;
		integ_rows = {3'b000, integration_rows_reg[`SPR_INTEG_MSB:0]} + 17'h0_0001;
		// A long integration count stretches the frame.
		if (integ_rows > norm_rows) begin
			frame_rows = integ_rows;
		end else begin
			frame_rows = norm_rows;
		end
	end

	// Scan control: idle between frames, scanning within one.
	always @* begin
		state_next = state_reg;
		col_next = col_reg;
		row_next = row_reg;
		case (state_reg)
			ST_IDLE: begin
				// A frame starts unless in standby; snapshot mode waits for the request.
				if (pix_step && !stby_s2_reg && (!snap_mode || snap_s2_reg)) begin
					state_next = ST_SCAN;
					col_next = 18'h0_0000;
					row_next = 17'h0_0000;
				end
			end
			ST_SCAN: begin
				if (pix_step) begin
					if (stby_s2_reg) begin
						// Standby abandons the frame at once.
						state_next = ST_IDLE;
					end else if (col_reg + 18'h0_0001 >= row_len) begin
						col_next = 18'h0_0000;
						if (row_reg + 17'h0_0001 >= frame_rows) begin
							state_next = ST_IDLE;
						end else begin
							row_next = row_reg + 17'h0_0001;
						end
					end else begin
						col_next = col_reg + 18'h0_0001;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Output qualifiers and pixel value for the position about to be shown.
	always @* begin
		in_cols = (col_next >= `SPR_P1_LEN) && (col_next < `SPR_P1_LEN + act_len);
		in_rows = (state_next == ST_SCAN) && (row_next < out_rows);
		pix_idx = col_next - `SPR_P1_LEN;
		// Raw-mode rows start at the top edge, normal rows inside the border.
		if (raw_mode) begin
			row_addr = row_next[10:0];
		end else begin
			row_addr = row_next[10:0] + `SPR_BLACK_TOP + `SPR_BORDER;
		end
		col_addr = pix_idx[10:0] + `SPR_BLACK_LEFT + `SPR_BORDER;
		// Frame active covers the output rows only; blanking rows stay low.
		fa_next = in_rows;
		if (readout_mode_reg[`SPR_MODE_LVFMT_BIT]) begin
			lv_next = in_rows;
		end else begin
			lv_next = in_rows && in_cols;
		end
		// Black border locations show the black level, others a position pattern.
		if (!lv_next) begin
			data_next = 10'h000;
		end else if (is_black(row_addr, col_addr)) begin
			data_next = BLACK_LEVEL;
		end else begin
			data_next = {row_addr[4:0], col_addr[4:0]};
		end
		// Reset done marks the first pixel step of every frame.
		strobe_next = (state_reg == ST_IDLE) && (state_next == ST_SCAN);
	end

	// Scan registers and outputs advance together on each master clock rising edge.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			col_reg <= 18'h0_0000;
			row_reg <= 17'h0_0000;
			pixel_data <= 10'h000;
			frame_active <= 1'b0;
			line_active <= 1'b0;
			reset_done <= 1'b0;
		end else begin
			state_reg <= state_next;
			col_reg <= col_next;
			row_reg <= row_next;
			if (pix_step) begin
				// Data change together with the pixel clock rising edge.
				pixel_data <= data_next;
				frame_active <= fa_next;
				line_active <= lv_next;
				reset_done <= strobe_next;
			end
		end
	end

	// Pixel clock copies the master clock level and never stops.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pixel_out_clock <= 1'b0;
		end else begin
			pixel_out_clock <= mclk_s2_reg;
		end
	end

	// Output enable, low while driving, and the analog bias indication.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			out_en_n <= 1'b1;
			analog_bias_on <= 1'b0;
		end else begin
			out_en_n <= oe_s2_reg;
			analog_bias_on <= ~stby_s2_reg;
		end
	end

endmodule
`default_nettype wire

// >>> hw/spr_readout_regs.vh
`ifndef SPR_READOUT_REGS_VH
`define SPR_READOUT_REGS_VH
// Register indexes on the register port.
`define SPR_ROW_SIZE_ADDR 8'h03
`define SPR_COL_SIZE_ADDR 8'h04
`define SPR_HBLANK_ADDR 8'h05
`define SPR_VBLANK_ADDR 8'h06
`define SPR_INTEG_ADDR 8'h09
`define SPR_MODE_ADDR 8'h20
`define SPR_STATUS_ADDR 8'h40
// Reset values of the registers.
`define SPR_ROW_SIZE_RST 16'h03FF
`define SPR_COL_SIZE_RST 16'h04FF
`define SPR_HBLANK_RST 16'h0009
`define SPR_VBLANK_RST 16'h0019
`define SPR_INTEG_RST 16'h0419
`define SPR_MODE_RST 16'h0000
// Field positions in the readout mode register, and the top used bit of the integration count.
`define SPR_MODE_RAW_BIT 11
`define SPR_MODE_LVFMT_BIT 9
`define SPR_MODE_SNAP_BIT 8
`define SPR_MODE_SKIP_LSB 2
`define SPR_INTEG_MSB 13
// Row timing figures, in pixel clocks.
`define SPR_HBLANK_MIN 16'h0013
`define SPR_P1_LEN 18'h0_00F2
`define SPR_P2_BASE 16'h0011
// Array geometry.
`define SPR_ARRAY_COLS 11'h520
`define SPR_ARRAY_ROWS 11'h418
`define SPR_BLACK_LEFT 11'h010
`define SPR_BLACK_TOP 11'h008
`define SPR_BLACK_RIGHT 11'h007
`define SPR_BLACK_BOTTOM 11'h007
`define SPR_ACTIVE_COLS 11'h509
`define SPR_ACTIVE_ROWS 11'h409
`define SPR_BORDER 11'h004
`endif

// >>> bench/spr_readout_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the pixel link and the control pins of the readout port.
module spr_readout_monitor (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic master_clock_in,
	input wire logic output_disable,
	input wire logic standby_req,
	input wire logic [9:0] pixel_data,
	input wire logic frame_active,
	input wire logic line_active,
	input wire logic pixel_out_clock,
	input wire logic reset_done,
	input wire logic out_en_n,
	input wire logic analog_bias_on
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic pclk_q; // Pixel clock one cycle ago.
	logic [3:0] still_cnt; // Cycles since the pixel clock last moved.
	logic [2:0] up_cnt; // Cycles since reset, saturating, until the synchroniser is flushed.
	// Counts how long the pixel clock has stood still.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pclk_q <= 1'b0;
			still_cnt <= 4'h0;
			up_cnt <= 3'h0;
		end else begin
			up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
			pclk_q <= pixel_out_clock;
			still_cnt <= (pixel_out_clock != pclk_q) ? 4'h0 : still_cnt + 4'h1;
		end
	end
	a_pclk_follow: assert property ((up_cnt == 3'h7) |->
		pixel_out_clock == $past(master_clock_in, 3)) else $error("pclk phase");
	a_pclk_alive: assert property (still_cnt < 4'hC) else $error("pclk stopped");
	a_data_on_rise: assert property ($changed(pixel_data) |-> $rose(pixel_out_clock))
		else $error("data off edge");
	a_qual_on_rise: assert property ($changed({frame_active, line_active}) |->
		$rose(pixel_out_clock)) else $error("qualifier off edge");
	a_line_in_frame: assert property (line_active |-> frame_active)
		else $error("line outside frame");
	a_done_at_start: assert property ($rose(frame_active) |-> reset_done)
		else $error("no done pulse");
	a_done_width: assert property ($rose(reset_done) |-> reset_done [*8] ##[3:6] !reset_done)
		else $error("done pulse width");
	a_oe_follow: assert property ($changed(out_en_n) |-> out_en_n == $past(output_disable, 3))
		else $error("float control");
	a_bias_off: assert property ($rose(standby_req) |-> ##[1:6] !analog_bias_on)
		else $error("bias stays on");
endmodule
bind spr_readout spr_readout_monitor i_spr_readout_monitor (.sys_clk(sys_clk), .resetn(resetn),
	.master_clock_in(master_clock_in), .output_disable(output_disable),
	.standby_req(standby_req), .pixel_data(pixel_data), .frame_active(frame_active),
	.line_active(line_active), .pixel_out_clock(pixel_out_clock), .reset_done(reset_done),
	.out_en_n(out_en_n), .analog_bias_on(analog_bias_on));
`default_nettype wire

// >>> bench/spr_grabber.sv
`timescale 1ns/100ps
`default_nettype none
// Capture side: measures lines and gaps on falling pixel clock edges.
module spr_grabber (
	input wire logic pixel_out_clock,
	input wire logic frame_active,
	input wire logic line_active,
	input wire logic out_en_n,
	input wire logic [9:0] pixel_data,
	output logic [9:0] first_pix,
	output logic [15:0] line_len,
	output logic [15:0] n_lines,
	output logic [15:0] gap
);
	logic [15:0] cnt = 16'h0000; // Pixels of the current line.
	logic [15:0] low = 16'h0000; // Quiet pixel clocks inside the frame.
	logic la_q = 1'b0; // Line qualifier at the previous sample.
	logic fa_q = 1'b0; // Frame qualifier at the previous sample.
	// Floated pins carry nothing, so samples are dropped while disabled.
	always @(negedge pixel_out_clock) begin
		if (!out_en_n) begin
			if (frame_active && !fa_q) begin
				n_lines <= 16'h0000;
			end
			if (line_active && !la_q) begin
				n_lines <= n_lines + 16'h0001;
				// The first pixel of the frame is kept for a value check.
				if (n_lines == 16'h0000) begin
					first_pix <= pixel_data;
				end
				gap <= low;
				cnt <= 16'h0001;
			end else if (line_active) begin
				cnt <= cnt + 16'h0001;
			end else if (la_q) begin
				line_len <= cnt;
			end
			low <= (frame_active && !line_active) ? low + 16'h0001 : 16'h0000;
			la_q <= line_active;
			fa_q <= frame_active;
		end
	end
endmodule
`default_nettype wire

// >>> bench/test_spr_readout.sv
`timescale 1ns/100ps
`default_nettype none
`include "spr_readout_regs.vh"
// Drives registers and controls, and measures frames through the grabber.
module test_spr_readout;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic master_clock_in = 1'b0;
	logic output_disable = 1'b0;
	logic snapshot_req = 1'b0;
	logic standby_req = 1'b1; // Held so no long default frame starts.
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	wire [15:0] reg_rdata, line_len, n_lines, gap;
	wire [9:0] pixel_data, first_pix;
	wire frame_active, line_active, pixel_out_clock, reset_done, out_en_n, analog_bias_on;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] rnd = 32'h0000_0023; // Random state.
	logic [15:0] col, hb, md; // Geometry of the next frame.
	logic [7:0] ra [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h20, 8'h7E};
	logic [15:0] rv [7] = '{`SPR_ROW_SIZE_RST, `SPR_COL_SIZE_RST, `SPR_HBLANK_RST,
		`SPR_VBLANK_RST, `SPR_INTEG_RST, `SPR_MODE_RST, 16'h0000};
	spr_readout i_spr_readout (.sys_clk, .resetn, .master_clock_in, .output_disable,
		.snapshot_req, .standby_req, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pixel_data, .frame_active, .line_active, .pixel_out_clock, .reset_done, .out_en_n,
		.analog_bias_on);
	spr_grabber i_spr_grabber (.pixel_out_clock, .frame_active, .line_active, .out_en_n,
		.pixel_data, .first_pix, .line_len, .n_lines, .gap);
	always #2 sys_clk = ~sys_clk;
	// Master clock of 48 ns with an unrelated phase.
	initial begin
		#7;
		forever #24 master_clock_in = ~master_clock_in;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	// Pixels per line for a column size and skip code.
	function automatic logic [15:0] exp_len(input logic [15:0] c, input logic [1:0] s);
		exp_len = (s == 2'b00) ? c + 16'h0001 : (c / (16'h0002 << s)) * 16'h0002 + 16'h0002;
	endfunction
	// Quiet clocks between two lines, with small blanking values clamped.
	function automatic logic [15:0] exp_gap(input logic [15:0] h);
		exp_gap = 16'h00F2 + ((h < 16'h0013) ? 16'h0013 : h) - 16'h0011;
	endfunction
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", reg_rdata, e);
	endtask
	// Stops readout, loads a geometry, then lets a fresh frame start.
	task cfg(input logic [15:0] rows, input logic [15:0] c, input logic [15:0] h,
		input logic [15:0] m);
		@(posedge sys_clk);
		standby_req <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk("bias", analog_bias_on, 16'h0000);
		chk("frame", frame_active, 16'h0000);
		wr(`SPR_ROW_SIZE_ADDR, rows);
		wr(`SPR_COL_SIZE_ADDR, c);
		wr(`SPR_HBLANK_ADDR, h);
		wr(`SPR_VBLANK_ADDR, 16'h0000);
		wr(`SPR_INTEG_ADDR, 16'h0000);
		wr(`SPR_MODE_ADDR, m);
		@(posedge sys_clk);
		standby_req <= 1'b0;
	endtask
	task frame;
		wait (frame_active === 1'b1);
		wait (frame_active === 1'b0);
		repeat (30) @(posedge sys_clk);
	endtask
	task give_verdict;
		$display("Checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
		for (int i = 0; i < 3; i++) begin
			rnd = xs(rnd);
			col = {10'h000, rnd[5:0]};
			hb = {11'h000, rnd[12:8]};
			md = {12'h000, rnd[17:16], 2'b00};
			if (i == 0) begin
				col = 16'h0010;
				hb = 16'h0012;
				md = 16'h000C;
			end
			cfg(16'h0001, col, hb, md);
			frame();
			chk("lines", n_lines, 16'h0002);
			chk("len", line_len, exp_len(col, md[3:2]));
			chk("gap", gap, exp_gap(hb));
			chk("pixel", {6'h00, first_pix}, 16'h0194);
		end
		cfg(16'h0000, 16'h0007, 16'h0013, 16'h0800);
		frame();
		chk("raw lines", n_lines, 16'h0010);
		chk("raw len", line_len, 16'h0008);
		chk("raw pixel", {6'h00, first_pix}, 16'h0020);
		cfg(16'h0001, 16'h0003, 16'h0013, 16'h0100);
		repeat (600) @(posedge sys_clk);
		chk("idle", frame_active, 16'h0000);
		snapshot_req <= 1'b1;
		repeat (60) @(posedge sys_clk);
		chk("snap", frame_active, 16'h0001);
		snapshot_req <= 1'b0;
		output_disable <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("float", out_en_n, 16'h0001);
		output_disable <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("drive", out_en_n, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
